// ### src/pinmux_consts.svh
`ifndef PINMUX_CONSTS_SVH
`define PINMUX_CONSTS_SVH

// Register offsets, as byte addresses on the register port.
`define OFF_CONTROL_ONE 10'h002
`define OFF_CONTROL_TWO 10'h004
`define OFF_PIN_FUNC 10'h00a
`define OFF_IRQ_SUMMARY 10'h010
`define OFF_IRQ_ENABLE 10'h012
`define OFF_PIN_LEVEL 10'h01c

// Reset values.
`define RST_CONTROL_ONE 16'h0000
`define RST_CONTROL_TWO 16'h0000
`define RST_PIN_FUNC 16'h0000
`define RST_IRQ_ENABLE 16'h0000

// Writable bits of each register; all others read as zero.
`define WMASK_CONTROL_ONE 16'h40f8
`define WMASK_CONTROL_TWO 16'h1f0f
`define WMASK_PIN_FUNC 16'hffff
`define WMASK_IRQ_ENABLE 16'h00f3

// Field positions in global_control_one.
`define BIT_IRQ_IDLE_DRIVE 14
`define BIT_MANUAL_ERR_INSERT 7
`define BIT_ERR_SRC_SELECT 6
`define POS_MONITOR_MODE 4
`define BIT_MONITOR_UPDATE 3

// Field positions in global_control_two.
`define BIT_REF_OUT_SELECT 9
`define BIT_REF_IN_SELECT 8
`define POS_ADAPTER_UPPER 2
`define POS_ADAPTER_LOWER 0

// Field positions in the summary register and its enable.
`define POS_PORT_SUMMARY 4
`define BIT_TX_SYSIF_SUMMARY 1
`define BIT_GLOBAL_SUMMARY 0

// Monitor update modes: 01 borrows pin 8, 00 takes the register bit.
`define MONITOR_MODE_PIN 2'h1
`define MONITOR_MODE_SOFT 2'h0

// Pin indices with a shared duty.
`define PIN_REF_OUT 1
`define PIN_REF_IN 3
`define PIN_ERR_IN 5
`define PIN_UPDATE_IN 7

`endif

// ### src/pinmux_pkg.sv
`default_nettype none
package pinmux_pkg;

    typedef enum logic [1:0] {
        FN_INPUT = 2'h0,
        FN_STATUS = 2'h1,
        FN_LOW = 2'h2,
        FN_HIGH = 2'h3
    } pin_fn_t;

    typedef enum logic [1:0] {
        RATE_ALL_INPUT = 2'h0,
        RATE_DS3 = 2'h1,
        RATE_E3 = 2'h2,
        RATE_STS1 = 2'h3
    } rate_kind_t;

    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] control_one;
        logic [15:0] control_two;
        logic [15:0] pin_func;
        logic [15:0] irq_enable;
        logic [15:0] rdata;
        logic irq_active;
    } state_t;

endpackage
`default_nettype wire

// ### src/global_pin_function_and_irq_summary.sv
// Notes on behaviour
// - Reference-out select drives pin 2 with reference.
// - Reference-in select takes pin 4 as reference.
// - Internal reference input low when not selected.
// - Upper adapter bits pick first-pin input clock.
// - DS3/E3 input: lower bits place other clocks.
// - STS-1 input placement; unused outputs stay low.
// - Pin select: input, status, low, high.
// - Status pins carry port A/B status pairs.
// - Pin 8 select ignored in pin update mode.
// - Pin 6 select honoured only with register source.
// - Pin 4 select honoured only without reference-in.
// - Pin 2 select honoured only without reference-out.
// - Port summary bit set when port flags set.
// - Transmit summary bit from enabled latched flags.
// - Global summary bit from enabled latched flags.
// - Interrupt pin low on enabled summary bit.
// - Idle interrupt pin floats or drives high.
// - Pin level register reports all eight pins.
// - Error-insert request taken from pin 6.
// - Monitor update request taken from pin 8.
//
// The implementer's own choice: the plain strobed port.
`include "pinmux_consts.svh"
`default_nettype none

module global_pin_function_and_irq_summary
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire pinmux_pkg::reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    // Sources of the summary bits
    input wire logic [63:0] port_interrupt_flags,
    input wire logic [15:0] tx_sysif_flags,
    input wire logic [15:0] tx_sysif_enables,
    input wire logic [15:0] global_latched_flags,
    input wire logic [15:0] global_latched_enables,
    // Per-port status, already chosen by each port's selectors
    input wire logic [3:0] port_status_a,
    input wire logic [3:0] port_status_b,
    // Reference and timing
    input wire logic global_ref_output,
    input wire logic one_second_tick,
    output logic internal_ref_input,
    output logic err_insert_request,
    output logic monitor_update_request,
    // General-purpose pins, index 0 is pin 1
    input wire logic [7:0] gpio_in,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe_n,
    // Rate clock pins, index 0 is the first pin
    input wire logic adapter_ds3_clk,
    input wire logic adapter_e3_clk,
    input wire logic adapter_sts1_clk,
    input wire logic [2:0] rate_pin_in,
    output logic [2:0] rate_pin_out,
    output logic [2:0] rate_pin_oe_n,
    output logic recovery_ref_clk,
    output pinmux_pkg::rate_kind_t recovery_ref_kind,
    // Interrupt pin
    output logic irq_out,
    output logic irq_oe_n
);
    import pinmux_pkg::*;

    state_t s;
    state_t next_s;
    logic [15:0] summary;
    logic [15:0] pin_level;
    logic [3:0] port_any;
    logic ref_out_sel;
    logic ref_in_sel;
    logic err_src_pin;
    logic [1:0] monitor_mode;
    rate_kind_t adapter_upper;
    logic [1:0] adapter_lower;
    logic partner_clk;
    logic rest_clk;

    assign ref_out_sel = s.control_two[`BIT_REF_OUT_SELECT];
    assign ref_in_sel = s.control_two[`BIT_REF_IN_SELECT];
    assign err_src_pin = s.control_one[`BIT_ERR_SRC_SELECT];
    assign monitor_mode = s.control_one[`POS_MONITOR_MODE +: 2];
    assign adapter_upper = rate_kind_t'(s.control_two[`POS_ADAPTER_UPPER +: 2]);
    assign adapter_lower = s.control_two[`POS_ADAPTER_LOWER +: 2];

    // Summary bits are pure functions of their sources, so they clear on their own
    // and nothing a write does can reach them.
    genvar p;
    generate
        for (p = 0; p < 4; p++)
        begin : g_port_any
            assign port_any[p] = |port_interrupt_flags[16*p +: 16];
        end
    endgenerate

    always_comb
    begin
        summary = 16'h0000;
        summary[`POS_PORT_SUMMARY +: 4] = port_any;
        summary[`BIT_TX_SYSIF_SUMMARY] = |(tx_sysif_flags & tx_sysif_enables);
        summary[`BIT_GLOBAL_SUMMARY] = |(global_latched_flags & global_latched_enables);
    end

    // The general-purpose and rate pin drivers are combinational so a reference or status level reaches
    // the pin without a cycle of skew; only reg_rdata and the interrupt pin drive are flopped.
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            logic forced_in;
            logic ref_drive;
            logic status_bit;
            pin_fn_t fn;
            assign forced_in = ((i == `PIN_REF_IN) && ref_in_sel)
                || ((i == `PIN_ERR_IN) && err_src_pin)
                || ((i == `PIN_UPDATE_IN) && (monitor_mode == `MONITOR_MODE_PIN));
            assign ref_drive = (i == `PIN_REF_OUT) && ref_out_sel;
            assign fn = forced_in ? FN_INPUT : pin_fn_t'(s.pin_func[2*i +: 2]);
            assign status_bit = (i % 2 == 0) ? port_status_a[i/2] : port_status_b[i/2];
            assign gpio_oe_n[i] = !(ref_drive || (fn != FN_INPUT));
            assign gpio_out[i] = ref_drive ? global_ref_output
                : ((fn == FN_HIGH) || ((fn == FN_STATUS) && status_bit));
            assign pin_level[i] = gpio_oe_n[i] ? gpio_in[i] : gpio_out[i];
        end
    endgenerate
    assign pin_level[15:8] = 8'h00;

    assign internal_ref_input = ref_in_sel ? gpio_in[`PIN_REF_IN] : 1'b0;
    assign err_insert_request = err_src_pin ? gpio_in[`PIN_ERR_IN]
        : s.control_one[`BIT_MANUAL_ERR_INSERT];

    always_comb
    begin
        if (monitor_mode == `MONITOR_MODE_PIN)
        begin
            monitor_update_request = gpio_in[`PIN_UPDATE_IN];
        end
        else if (monitor_mode == `MONITOR_MODE_SOFT)
        begin
            monitor_update_request = s.control_one[`BIT_MONITOR_UPDATE];
        end
        else
        begin
            monitor_update_request = one_second_tick;
        end
    end

    // The partner clock is the one placed alone on the second pin by lower code 01;
    // the rest clock is the one placed alone on the third pin by lower code 10.
    always_comb
    begin
        unique case (adapter_upper)
            RATE_DS3:
            begin
                partner_clk = adapter_e3_clk;
                rest_clk = adapter_sts1_clk;
            end
            RATE_E3:
            begin
                partner_clk = adapter_ds3_clk;
                rest_clk = adapter_sts1_clk;
            end
            RATE_STS1:
            begin
                partner_clk = adapter_e3_clk;
                rest_clk = adapter_ds3_clk;
            end
            RATE_ALL_INPUT:
            begin
                partner_clk = 1'b0;
                rest_clk = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        rate_pin_out = 3'h0;
        rate_pin_oe_n = 3'h1;
        if (adapter_upper == RATE_ALL_INPUT)
        begin
            rate_pin_oe_n = 3'h7;
        end
        else
        begin
            unique case (adapter_lower)
                2'h1: rate_pin_out[1] = partner_clk;
                2'h2: rate_pin_out[2] = rest_clk;
                2'h3: rate_pin_out[2:1] = {partner_clk, rest_clk};
                2'h0: rate_pin_out = 3'h0;
            endcase
        end
    end

    // In mode 00 the first pin still means DS3, so the recovery reference is that pin.
    assign recovery_ref_clk = rate_pin_in[0];
    assign recovery_ref_kind = (adapter_upper == RATE_ALL_INPUT) ? RATE_DS3 : adapter_upper;

    always_comb
    begin
        next_s = s;
        next_s.rdata = 16'h0000;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                `OFF_CONTROL_ONE: next_s.control_one = reg_req.wdata & `WMASK_CONTROL_ONE;
                `OFF_CONTROL_TWO: next_s.control_two = reg_req.wdata & `WMASK_CONTROL_TWO;
                `OFF_PIN_FUNC: next_s.pin_func = reg_req.wdata & `WMASK_PIN_FUNC;
                `OFF_IRQ_ENABLE: next_s.irq_enable = reg_req.wdata & `WMASK_IRQ_ENABLE;
                default: next_s.rdata = 16'h0000;
            endcase
        end
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                `OFF_CONTROL_ONE: next_s.rdata = s.control_one;
                `OFF_CONTROL_TWO: next_s.rdata = s.control_two;
                `OFF_PIN_FUNC: next_s.rdata = s.pin_func;
                `OFF_IRQ_SUMMARY: next_s.rdata = summary;
                `OFF_IRQ_ENABLE: next_s.rdata = s.irq_enable;
                `OFF_PIN_LEVEL: next_s.rdata = pin_level;
                default: next_s.rdata = 16'h0000;
            endcase
        end
        next_s.irq_active = |(summary & s.irq_enable);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s.control_one <= `RST_CONTROL_ONE;
            s.control_two <= `RST_CONTROL_TWO;
            s.pin_func <= `RST_PIN_FUNC;
            s.irq_enable <= `RST_IRQ_ENABLE;
            s.rdata <= 16'h0000;
            s.irq_active <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;

    // Idle behaviour of the interrupt pin lets several devices share one wire.
    assign irq_out = !s.irq_active && s.control_one[`BIT_IRQ_IDLE_DRIVE];
    assign irq_oe_n = !s.irq_active && !s.control_one[`BIT_IRQ_IDLE_DRIVE];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_ref_out;
        ref_out_sel |-> (!gpio_oe_n[1] && (gpio_out[1] == global_ref_output));
    endproperty
    a_ref_out: assert property (p_ref_out) else $error("pin 2 not carrying reference");

    property p_ref_in;
        internal_ref_input == (ref_in_sel && gpio_in[3]);
    endproperty
    a_ref_in: assert property (p_ref_in) else $error("internal reference wrong");

    property p_ref_in_pin;
        ref_in_sel |-> gpio_oe_n[3];
    endproperty
    a_ref_in_pin: assert property (p_ref_in_pin) else $error("pin 4 driven as ref");

    property p_pin8_ignored;
        (monitor_mode == `MONITOR_MODE_PIN) |-> (gpio_oe_n[7]
            && (monitor_update_request == gpio_in[7]));
    endproperty
    a_pin8_ignored: assert property (p_pin8_ignored) else $error("pin 8 not update");

    property p_pin6_src;
        err_src_pin |-> (gpio_oe_n[5] && (err_insert_request == gpio_in[5]));
    endproperty
    a_pin6_src: assert property (p_pin6_src) else $error("pin 6 not error input");

    property p_pin1_fn;
        (s.pin_func[1:0] == 2'h2) |-> (!gpio_oe_n[0] && !gpio_out[0]);
    endproperty
    a_pin1_fn: assert property (p_pin1_fn) else $error("pin 1 not driven low");

    property p_pin3_status;
        (s.pin_func[5:4] == 2'h1) |-> (!gpio_oe_n[2] && (gpio_out[2] == port_status_a[1]));
    endproperty
    a_pin3_status: assert property (p_pin3_status) else $error("pin 3 status wrong");

    property p_rate_inputs;
        (adapter_upper == RATE_ALL_INPUT) |-> (rate_pin_oe_n == 3'h7);
    endproperty
    a_rate_inputs: assert property (p_rate_inputs) else $error("rate pins not inputs");

    property p_rate_low;
        ((adapter_upper != RATE_ALL_INPUT) && (adapter_lower == 2'h0))
            |-> ((rate_pin_oe_n == 3'h1) && (rate_pin_out == 3'h0));
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("rate outputs not low");

    property p_irq_assert;
        (|(summary & s.irq_enable)) |=> (!irq_out && !irq_oe_n);
    endproperty
    a_irq_assert: assert property (p_irq_assert) else $error("interrupt pin not low");

    property p_irq_idle;
        !(|(summary & s.irq_enable)) |=> ((irq_out == s.control_one[`BIT_IRQ_IDLE_DRIVE])
            && (irq_oe_n != s.control_one[`BIT_IRQ_IDLE_DRIVE]));
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("idle interrupt pin wrong");

    property p_summary_read;
        (reg_req.rd && (reg_req.addr == `OFF_IRQ_SUMMARY)) |=> (reg_rdata == $past(summary));
    endproperty
    a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

    property p_port_summary;
        (|port_interrupt_flags[15:0]) |-> summary[4];
    endproperty
    a_port_summary: assert property (p_port_summary) else $error("port 1 summary low");

    property p_level_read;
        (reg_req.rd && (reg_req.addr == `OFF_PIN_LEVEL)) |=> (reg_rdata[15:8] == 8'h00)
            && (reg_rdata[7:0] == $past(pin_level[7:0]));
    endproperty
    a_level_read: assert property (p_level_read) else $error("pin level read wrong");

    property p_pin1_high;
        (s.pin_func[1:0] == 2'h3) |-> (!gpio_oe_n[0] && gpio_out[0]);
    endproperty
    a_pin1_high: assert property (p_pin1_high) else $error("pin 1 not driven high");

    property p_pin2_status;
        (!ref_out_sel && (s.pin_func[3:2] == 2'h1))
            |-> (!gpio_oe_n[1] && (gpio_out[1] == port_status_b[0]));
    endproperty
    a_pin2_status: assert property (p_pin2_status) else $error("pin 2 select lost");

    property p_pin4_sel;
        (!ref_in_sel && (s.pin_func[7:6] == 2'h2)) |-> (!gpio_oe_n[3] && !gpio_out[3]);
    endproperty
    a_pin4_sel: assert property (p_pin4_sel) else $error("pin 4 select lost");

    property p_pin6_sel;
        (!err_src_pin && (s.pin_func[11:10] == 2'h3)) |-> (!gpio_oe_n[5] && gpio_out[5]);
    endproperty
    a_pin6_sel: assert property (p_pin6_sel) else $error("pin 6 select lost");

    property p_pin8_status;
        ((monitor_mode != `MONITOR_MODE_PIN) && (s.pin_func[15:14] == 2'h1))
            |-> (!gpio_oe_n[7] && (gpio_out[7] == port_status_b[3]));
    endproperty
    a_pin8_status: assert property (p_pin8_status) else $error("pin 8 status wrong");

    property p_rate_ds3;
        ((adapter_upper == RATE_DS3) && (adapter_lower == 2'h1))
            |-> ((rate_pin_oe_n == 3'h1) && (rate_pin_out == {1'b0, adapter_e3_clk, 1'b0}));
    endproperty
    a_rate_ds3: assert property (p_rate_ds3) else $error("DS3 rate pins wrong");

    property p_rate_sts1;
        ((adapter_upper == RATE_STS1) && (adapter_lower == 2'h3))
            |-> (rate_pin_out == {adapter_e3_clk, adapter_ds3_clk, 1'b0});
    endproperty
    a_rate_sts1: assert property (p_rate_sts1) else $error("STS-1 rate pins wrong");

    property p_tx_summary;
        summary[`BIT_TX_SYSIF_SUMMARY] == |(tx_sysif_flags & tx_sysif_enables);
    endproperty
    a_tx_summary: assert property (p_tx_summary) else $error("transmit summary wrong");

    property p_glb_summary;
        summary[`BIT_GLOBAL_SUMMARY] == |(global_latched_flags & global_latched_enables);
    endproperty
    a_glb_summary: assert property (p_glb_summary) else $error("global summary wrong");

endmodule
`default_nettype wire

// ### dv/board_model.sv
`default_nettype none

module board_model
(
    // Pin drives from the device
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe_n,
    input wire logic [2:0] rate_pin_out,
    input wire logic [2:0] rate_pin_oe_n,
    input wire logic irq_out,
    input wire logic irq_oe_n,
    // Values the board puts on released pins
    input wire logic [7:0] board_gpio,
    input wire logic [2:0] board_rate,
    // Resolved wire levels
    output logic [7:0] gpio_lvl,
    output logic [2:0] rate_lvl,
    output logic irq_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // The board drives only what the device releases, so contention is not modelled.
    assign gpio_lvl = (gpio_oe_n & board_gpio) | (~gpio_oe_n & gpio_out);
    assign rate_lvl = (rate_pin_oe_n & board_rate) | (~rate_pin_oe_n & rate_pin_out);
    // The interrupt line carries a pull-up, so a floating pin reads high.
    assign irq_lvl = irq_oe_n ? 1'b1 : irq_out;
endmodule

`default_nettype wire

// ### dv/global_pin_function_and_irq_summary_tb_top.sv
`include "pinmux_consts.svh"
`default_nettype none

module global_pin_function_and_irq_summary_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, ref_o, tick, iref, err_req, mon_req, ds, e3, sts;
    logic rec_clk, irq_out, irq_oe_n, irq_lvl;
    pinmux_pkg::reg_req_t reg_req;
    pinmux_pkg::rate_kind_t rec_kind;
    logic [63:0] pflags;
    logic [15:0] reg_rdata, tf, te, gf, ge, f, c1, c2, r1, r2, en, rv, e;
    logic [3:0] sa, sb;
    logic [7:0] gpio_in, gpio_out, gpio_oe_n, board_gpio, sum;
    logic [2:0] rate_in, rate_out, rate_oe_n, board_rate;
    logic [5:0] ra;
    integer seed = 94;
    int bad_count = 0;
    int checked = 0;

    global_pin_function_and_irq_summary dut (.core_clk(core_clk), .nrst(nrst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .port_interrupt_flags(pflags),
        .tx_sysif_flags(tf), .tx_sysif_enables(te), .global_latched_flags(gf),
        .global_latched_enables(ge), .port_status_a(sa), .port_status_b(sb),
        .global_ref_output(ref_o), .one_second_tick(tick), .internal_ref_input(iref),
        .err_insert_request(err_req), .monitor_update_request(mon_req),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .adapter_ds3_clk(ds), .adapter_e3_clk(e3), .adapter_sts1_clk(sts),
        .rate_pin_in(rate_in), .rate_pin_out(rate_out), .rate_pin_oe_n(rate_oe_n),
        .recovery_ref_clk(rec_clk), .recovery_ref_kind(rec_kind),
        .irq_out(irq_out), .irq_oe_n(irq_oe_n));

    board_model board (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .rate_pin_out(rate_out), .rate_pin_oe_n(rate_oe_n), .irq_out(irq_out),
        .irq_oe_n(irq_oe_n), .board_gpio(board_gpio), .board_rate(board_rate),
        .gpio_lvl(gpio_in), .rate_lvl(rate_in), .irq_lvl(irq_lvl));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task test_done;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask

    task rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // Expected {enables, wire levels} of the eight general-purpose pins.
    function automatic logic [15:0] pin_exp(input logic [15:0] f, c1, c2);
        logic [7:0] oe, lv;
        logic [1:0] fn;
        logic hold;
        for (int i = 0; i < 8; i++)
        begin
            fn = f[2*i +: 2];
            hold = (i == 3 && c2[8]) || (i == 5 && c1[6]) || (i == 7 && c1[5:4] == 2'h1);
            oe[i] = 1'b0;
            if (i == 1 && c2[9])
                lv[i] = ref_o;
            else if (hold || fn == 2'h0)
                {oe[i], lv[i]} = {1'b1, board_gpio[i]};
            else
                lv[i] = fn == 2'h1 ? (i % 2 ? sb[i/2] : sa[i/2]) : fn[0];
        end
        return {oe, lv};
    endfunction

    // Expected {enables, levels} of the rate pins; partner and rest clocks per input kind.
    function automatic logic [5:0] rate_exp(input logic [3:0] c);
        logic p, r;
        p = c[3:2] == 2'h2 ? ds : e3;
        r = c[3:2] == 2'h3 ? ds : sts;
        if (c[3:2] == 2'h0)
            return {3'b111, board_rate};
        return {3'b001, c[1:0] == 2'h2 ? r : (c[1:0] == 2'h3 ? p : 1'b0),
            c[1:0] == 2'h1 ? p : (c[1:0] == 2'h3 ? r : 1'b0), board_rate[0]};
    endfunction

    initial
    begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        test_done;
    end

    initial
    begin
        nrst = 1'b0;
        reg_req = '0;
        {pflags, tf, te, gf, ge, sa, sb, ref_o, tick, ds, e3, sts} = '0;
        board_gpio = 8'h00;
        board_rate = 3'h0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk({irq_oe_n, gpio_oe_n, rate_oe_n}, 12'hfff);
        rd(`OFF_PIN_FUNC, rv);
        chk(rv, `RST_PIN_FUNC);
        rd(`OFF_IRQ_ENABLE, rv);
        chk(rv, `RST_IRQ_ENABLE);
        rd(10'h3fe, rv);
        chk(rv, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 40; i++)
        begin
            f = 16'($random(seed));
            r1 = 16'($random(seed));
            r2 = (16'($random(seed)) & 16'hfff0) | {12'h000, i[3:0]};
            if (i == 0)
                {f, r1, r2} = {16'hffff, 16'hbfdf, 16'hffff};
            c1 = r1 & `WMASK_CONTROL_ONE;
            c2 = r2 & `WMASK_CONTROL_TWO;
            wr(`OFF_PIN_FUNC, f);
            wr(`OFF_CONTROL_ONE, r1);
            wr(`OFF_CONTROL_TWO, r2);
            @(posedge core_clk);
            board_gpio <= 8'($random(seed));
            board_rate <= 3'($random(seed));
            {sa, sb, ref_o, tick, ds, e3, sts} <= 13'($random(seed));
            settle;
            e = pin_exp(f, c1, c2);
            chk(gpio_oe_n, e[15:8]);
            chk(gpio_in, e[7:0]);
            rd(`OFF_PIN_LEVEL, rv);
            chk(rv, {8'h00, e[7:0]});
            rd(`OFF_CONTROL_ONE, rv);
            chk(rv, c1);
            rd(`OFF_CONTROL_TWO, rv);
            chk(rv, c2);
            ra = rate_exp(c2[3:0]);
            chk({rate_oe_n, rate_in}, ra);
            chk(rec_kind, c2[3:2] == 2'h0 ? 2'h1 : c2[3:2]);
            chk(rec_clk, board_rate[0]);
            chk(iref, c2[8] ? e[3] : 1'b0);
            chk(err_req, c1[6] ? e[5] : c1[7]);
            chk(mon_req, c1[5:4] == 2'h1 ? e[7] : (c1[5] ? tick : c1[3]));
        end
        $display("test pins done");
        for (int i = 0; i < 30; i++)
        begin
            en = 16'($random(seed));
            r1 = 16'($random(seed));
            wr(`OFF_IRQ_ENABLE, en);
            wr(`OFF_CONTROL_ONE, r1);
            @(posedge core_clk);
            // The last pass clears every source so the idle pin level is seen too.
            if (i == 29)
            begin
                {pflags, tf, te, gf, ge} <= '0;
            end
            else
            begin
                for (int p = 0; p < 4; p++)
                    pflags[16*p +: 16] <= ($random(seed) & 3) == 0
                        ? 16'h1 << ($random(seed) & 15) : 16'h0000;
                {tf, te} <= $random(seed) & $random(seed);
                {gf, ge} <= $random(seed) & $random(seed);
            end
            settle;
            sum = {|pflags[63:48], |pflags[47:32], |pflags[31:16], |pflags[15:0], 2'b00,
                |(tf & te), |(gf & ge)};
            rd(`OFF_IRQ_SUMMARY, rv);
            chk(rv, {8'h00, sum});
            wr(`OFF_IRQ_SUMMARY, 16'hffff);
            rd(`OFF_IRQ_SUMMARY, rv);
            chk(rv, {8'h00, sum});
            rd(`OFF_IRQ_ENABLE, rv);
            chk(rv, en & `WMASK_IRQ_ENABLE);
            chk({irq_oe_n, irq_lvl}, |(sum & en) ? 2'b00 : {~r1[14], 1'b1});
        end
        $display("test interrupt done");
        test_done;
    end
endmodule

`default_nettype wire
